//--- design/sps_pkg.sv
/*
 * Shared constants and carrier types for the pipelined static memory port.
 * Assumes a bus master on the same core_clk driving all synchronous pins.
 */
// How it works
// - word address captured on rising edge only
// - two low bits preset the burst counter
// - low lane enable writes byte in writes
// - lane enables registered, applied to later data
// - enable a..d gate lanes a..d respectively
// - every enabled edge captures enables; loads add address, selects
// - selected when primary low, low low, high high
// - chip selects sampled only on load cycles
// - output enable async, gates data drivers only
// - advance steps counter, continues loaded burst
// - read/write ignored during advance cycles
// - load low takes new address, new cycle
// - clock enable high freezes pipeline; queued writes still drain
// - sleep keeps array contents in standby
// - sleep ignores every other input but reset; the clock only runs the synchroniser
// - write data taken two edges after address
// - burst wraps to base after four accesses
// - read/write low write, high read, at load
package sps_pkg;
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;
   localparam int WORD_ADDR_W = 17;
   localparam int FIFO_DEPTH  = 32;
   localparam int SYNC_STAGES = 3;
   localparam logic [1:0] BURST_START = 2'h0;
   localparam logic [1:0] BURST_STEP  = 2'h1;

   typedef logic [LANES-1:0][LANE_W-1:0] sps_word_t;

   typedef struct packed {
      logic                   valid;
      logic                   write;
      logic [WORD_ADDR_W-1:0] addr;
      logic [LANES-1:0]       be;
   } sps_stage_s;

   typedef struct packed {
      logic [WORD_ADDR_W-1:0] addr;
      sps_word_t              data;
      logic [LANES-1:0]       be;
   } sps_wrec_s;

   localparam sps_stage_s STAGE_IDLE = '0;
endpackage

//--- design/sps_port.sv
/*
 * Write-record FIFO and the pipelined static memory port itself.
 * Assumes all synchronous inputs come from logic on core_clk; the sleep
 * request is asynchronous. Pin level is resolved outside from *_oe.
 */
`timescale 1ns/10ps

// ****************************************************************
// write-record fifo
// ****************************************************************
module sps_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   input  wire logic         core_clk,  // clock
   input  wire logic         rst_b,     // async reset, low
   input  wire logic         in_valid,  // push request
   output logic              in_ready,  // not full
   input  wire logic [W-1:0] in_data,   // pushed word
   output logic              out_valid, // not empty
   input  wire logic         out_ready, // pop request
   output logic [W-1:0]      out_data   // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ****************************************************************
// memory port
// ****************************************************************
module sps_port #(
   parameter int FIFO_DEPTH = sps_pkg::FIFO_DEPTH
) (
   input  wire logic   core_clk,           // clock
   input  wire logic   rst_b,              // async reset, low
   input  wire logic [sps_pkg::WORD_ADDR_W-3:0]
                       word_address_in,    // upper word address
   input  wire logic   burst_lsb_0,        // address bit 0
   input  wire logic   burst_lsb_1,        // address bit 1
   input  wire logic   chip_select_n,      // primary select, low
   input  wire logic   depth_select_low_n, // depth select, low
   input  wire logic   depth_select_high,  // depth select, high
   input  wire logic   load_advance,       // low load, high advance
   input  wire logic   read_write_n,       // high read, low write
   input  wire logic   lane_a_write_n,     // lane a write, low
   input  wire logic   lane_b_write_n,     // lane b write, low
   input  wire logic   lane_c_write_n,     // lane c write, low
   input  wire logic   lane_d_write_n,     // lane d write, low
   input  wire logic   clock_enable_n,     // clock enable, low
   input  wire logic   output_enable_n,    // async output enable
   input  wire logic   sleep_request,      // async standby, high
   input  wire logic   burst_order_select, // low linear, high ilv
   input  wire logic [sps_pkg::LANE_W-1:0]
                       data_lane_a_in,     // lane a pin level
   input  wire logic [sps_pkg::LANE_W-1:0]
                       data_lane_b_in,     // lane b pin level
   input  wire logic [sps_pkg::LANE_W-1:0]
                       data_lane_c_in,     // lane c pin level
   input  wire logic [sps_pkg::LANE_W-1:0]
                       data_lane_d_in,     // lane d pin level
   output logic [sps_pkg::LANE_W-1:0]
                       data_lane_a_out,    // lane a drive value
   output logic [sps_pkg::LANE_W-1:0]
                       data_lane_b_out,    // lane b drive value
   output logic [sps_pkg::LANE_W-1:0]
                       data_lane_c_out,    // lane c drive value
   output logic [sps_pkg::LANE_W-1:0]
                       data_lane_d_out,    // lane d drive value
   output logic        data_lane_a_oe,     // lane a driven, high
   output logic        data_lane_b_oe,     // lane b driven, high
   output logic        data_lane_c_oe,     // lane c driven, high
   output logic        data_lane_d_oe      // lane d driven, high
);
   localparam int AW = sps_pkg::WORD_ADDR_W;
   localparam int RW = $bits(sps_pkg::sps_wrec_s);

   sps_pkg::sps_word_t  array_q [2**AW];
   sps_pkg::sps_word_t  pin_word;
   sps_pkg::sps_word_t  rd_q;
   sps_pkg::sps_word_t  rd_d;
   sps_pkg::sps_stage_s s1_q;
   sps_pkg::sps_stage_s s2_q;
   sps_pkg::sps_wrec_s  push_rec;
   sps_pkg::sps_wrec_s  head_rec;
   logic [RW-1:0]       head_bits;
   logic [sps_pkg::SYNC_STAGES-1:0] sleep_sync_q;
   logic                sleep_on_q;
   logic [AW-3:0]       base_q;
   logic [1:0]          base_lsb_q;
   logic [1:0]          cnt_q;
   logic [1:0]          cnt_d;
   logic                drive_q;
   logic                selected;
   logic                step;
   logic                push;
   logic                push_ready;
   logic                head_valid;
   logic                drain;
   logic [sps_pkg::LANES-1:0] be_in;

   assign pin_word = {data_lane_d_in, data_lane_c_in,
                      data_lane_b_in, data_lane_a_in};
   assign be_in    = ~{lane_d_write_n, lane_c_write_n,
                       lane_b_write_n, lane_a_write_n};
   assign selected = !chip_select_n && !depth_select_low_n
                     && depth_select_high;
   // sleep and back-pressure stall the whole pipeline like a held clock
   assign step     = !clock_enable_n && !sleep_on_q && push_ready;
   assign cnt_d    = cnt_q + sps_pkg::BURST_STEP;

   // ****************************************************************
   // sleep synchroniser
   // ****************************************************************
   // stage 0 feeds only stage 1; a change needs stages 1 and 2 to agree
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_sync_q <= '0;
         sleep_on_q   <= 1'b0;
      end else begin
         sleep_sync_q <= {sleep_sync_q[1:0], sleep_request};
         if (sleep_sync_q[1] == sleep_sync_q[2]) begin
            sleep_on_q <= sleep_sync_q[2];
         end
      end
   end

   // ****************************************************************
   // address load and burst counter
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         base_q     <= '0;
         base_lsb_q <= '0;
         cnt_q      <= sps_pkg::BURST_START;
         s1_q       <= sps_pkg::STAGE_IDLE;
      end else if (step) begin
         s1_q.be <= be_in;
         if (!load_advance) begin
            base_q       <= word_address_in;
            base_lsb_q   <= {burst_lsb_1, burst_lsb_0};
            cnt_q        <= sps_pkg::BURST_START;
            s1_q.addr    <= {word_address_in, burst_lsb_1, burst_lsb_0};
            s1_q.valid   <= selected;
            s1_q.write   <= !read_write_n;
         end else begin
            cnt_q <= cnt_d;
            // linear adds the count, interleaved xors it
            s1_q.addr <= {base_q, burst_order_select
                          ? (base_lsb_q ^ cnt_d)
                          : (base_lsb_q + cnt_d)};
         end
      end
   end

   // ****************************************************************
   // data stage: late write capture and registered read
   // ****************************************************************
   assign push     = step && s2_q.valid && s2_q.write;
   assign push_rec = '{addr: s2_q.addr, data: pin_word,
                       be: s2_q.be};
   assign head_rec = sps_pkg::sps_wrec_s'(head_bits);
   // drain holds off while asleep so no array write lands in standby
   assign drain    = head_valid && !sleep_on_q;

   // the head may still be on its way into the array; merge it in
   always_comb begin
      rd_d = array_q[s2_q.addr];
      for (int i = 0; i < sps_pkg::LANES; i++) begin
         if (head_valid && head_rec.addr == s2_q.addr
             && head_rec.be[i]) begin
            rd_d[i] = head_rec.data[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s2_q    <= sps_pkg::STAGE_IDLE;
         rd_q    <= '0;
         drive_q <= 1'b0;
      end else if (step) begin
         s2_q    <= s1_q;
         drive_q <= s2_q.valid && !s2_q.write;
         if (s2_q.valid && !s2_q.write) begin
            rd_q <= rd_d;
         end
      end
   end

   sps_fifo #(
      .W     (RW),
      .DEPTH (FIFO_DEPTH)
   ) u_wfifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   (push_rec),
      .out_valid (head_valid),
      .out_ready (!sleep_on_q),
      .out_data  (head_bits)
   );

   always_ff @(posedge core_clk) begin
      if (drain) begin
         for (int i = 0; i < sps_pkg::LANES; i++) begin
            if (head_rec.be[i]) begin
               array_q[head_rec.addr][i] <= head_rec.data[i];
            end
         end
      end
   end

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   assign data_lane_a_out = rd_q[0];
   assign data_lane_b_out = rd_q[1];
   assign data_lane_c_out = rd_q[2];
   assign data_lane_d_out = rd_q[3];
   // async gate: output enable reaches the drivers without a clock
   assign data_lane_a_oe = drive_q && !output_enable_n && !sleep_on_q;
   assign data_lane_b_oe = data_lane_a_oe;
   assign data_lane_c_oe = data_lane_a_oe;
   assign data_lane_d_oe = data_lane_a_oe;

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence load_s(logic rd);
      step && !load_advance && selected && (read_write_n == rd);
   endsequence

   a_read_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b1) ##1 step ##1 step |=> drive_q)
      else $error("read data not driven two edges after address");

   a_desel_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
      (step && !load_advance && !selected) ##1 step ##1 step
      |=> !drive_q)
      else $error("deselected load drove the data pins");

   a_oe_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      output_enable_n |-> !data_lane_a_oe && !data_lane_d_oe)
      else $error("data driven while output enable high");

   a_suspend_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      clock_enable_n |=> $stable(s1_q) && $stable(s2_q)
                         && $stable(rd_q) && $stable(drive_q))
      else $error("state moved on a suspended edge");

   a_burst_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
      (step && !load_advance) ##1 (step && load_advance)[*4]
      |=> s1_q.addr == $past(s1_q.addr, 4))
      else $error("burst did not wrap after four accesses");

   a_adv_keeps: assert property (@(posedge core_clk) disable iff (!rst_b)
      step && load_advance |=> $stable(s1_q.write)
                               && $stable(s1_q.valid))
      else $error("advance changed cycle type or select");

   a_addr_load: assert property (@(posedge core_clk) disable iff (!rst_b)
      step && !load_advance |=> s1_q.addr == $past({word_address_in,
                                 burst_lsb_1, burst_lsb_0}))
      else $error("loaded address not captured");

   a_write_late: assert property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b0) ##1 step ##1 step |-> push
      && push_rec.be == $past(be_in, 2) && push_rec.data == pin_word)
      else $error("write data not taken two edges after address");

   a_sleep_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
      sleep_on_q |=> $stable(s1_q) && $stable(rd_q) && !drain)
      else $error("activity while asleep");

   c_read: cover property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b1) ##1 step ##1 step ##1 data_lane_a_oe);
   c_write: cover property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b0) ##1 step ##1 step ##0 push);
   c_burst: cover property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b1) ##1 (step && load_advance)[*3]);
   c_suspend: cover property (@(posedge core_clk) disable iff (!rst_b)
      load_s(1'b1) ##1 clock_enable_n[*2] ##1 step);
endmodule

//--- sim/sps_bus_model.sv
/*
 * Bus master model for the shared data lanes of the memory port.
 * Assumes lane a in bits 8:0 up to lane d in bits 35:27, one core_clk.
 */
`timescale 1ns/10ps

// ****************************************************************
// lane resolver
// ****************************************************************
module sps_bus_model (
   input  wire logic              core_clk, // clock
   input  wire logic              drive,    // master drives write data
   input  wire sps_pkg::sps_word_t wdata,   // master write data
   input  wire sps_pkg::sps_word_t dev_out, // device drive values
   input  wire logic [3:0]        dev_oe,   // device lane enables
   output sps_pkg::sps_word_t     pins      // resolved lane levels
);
   sps_pkg::sps_word_t last_q = '0;

   always @(posedge core_clk) last_q <= pins;

   // no pull on the lanes: a released lane shows the inverse level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (dev_oe[i]) pins[i] = dev_out[i];
         else if (drive) pins[i] = wdata[i];
         else pins[i] = ~last_q[i];
      end
   end
endmodule

//--- sim/sps_port_bench.sv
/*
 * Self-checking bench for the pipelined static memory port.
 * Assumes the bus model resolves the lanes; inputs change 1 ns after edges.
 */
`timescale 1ns/10ps

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   err_total++; $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); \
   end end

// ****************************************************************
// bench top
// ****************************************************************
module sps_port_bench;
   localparam logic [2:0] SEL = 3'h1;
   localparam logic [2:0] IDL = 3'h4;
   logic core_clk, rst_b, burst_lsb_0, burst_lsb_1, chip_select_n;
   logic depth_select_low_n, depth_select_high, load_advance;
   logic read_write_n, lane_a_write_n, lane_b_write_n, lane_c_write_n;
   logic lane_d_write_n, clock_enable_n, output_enable_n, sleep_request;
   logic burst_order_select, drive;
   logic [sps_pkg::WORD_ADDR_W-3:0] word_address_in;
   logic [8:0] data_lane_a_out, data_lane_b_out;
   logic [8:0] data_lane_c_out, data_lane_d_out;
   logic data_lane_a_oe, data_lane_b_oe, data_lane_c_oe, data_lane_d_oe;
   sps_pkg::sps_word_t wdata, pins, rd_w;
   sps_pkg::sps_word_t mem [0:7];
   logic [3:0] oe_w;
   int err_total = 0;
   int samples_checked = 0;

   assign rd_w = {data_lane_d_out, data_lane_c_out,
                  data_lane_b_out, data_lane_a_out};
   assign oe_w = {data_lane_d_oe, data_lane_c_oe,
                  data_lane_b_oe, data_lane_a_oe};

   sps_port uut (.core_clk, .rst_b, .word_address_in, .burst_lsb_0,
      .burst_lsb_1, .chip_select_n, .depth_select_low_n, .depth_select_high,
      .load_advance, .read_write_n, .lane_a_write_n, .lane_b_write_n,
      .lane_c_write_n, .lane_d_write_n, .clock_enable_n, .output_enable_n,
      .sleep_request, .burst_order_select, .data_lane_a_in(pins[0]),
      .data_lane_b_in(pins[1]), .data_lane_c_in(pins[2]),
      .data_lane_d_in(pins[3]), .data_lane_a_out, .data_lane_b_out,
      .data_lane_c_out, .data_lane_d_out, .data_lane_a_oe, .data_lane_b_oe,
      .data_lane_c_oe, .data_lane_d_oe);

   sps_bus_model master (.core_clk, .drive, .wdata, .dev_out(rd_w),
      .dev_oe(oe_w), .pins);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic sps_pkg::sps_word_t pat(input logic [16:0] a);
      return {4{a[8:0]}} ^ 36'h9a5c3b71e;
   endfunction

   // one bus cycle; write data is for the address two loads back
   task automatic step(input logic ld, input logic rw, input logic [16:0] a,
                       input logic [3:0] ben, input logic [2:0] sel,
                       input logic dv, input sps_pkg::sps_word_t d);
      load_advance = ld;
      read_write_n = rw;
      word_address_in = a[16:2];
      {burst_lsb_1, burst_lsb_0} = a[1:0];
      {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = ben;
      {chip_select_n, depth_select_low_n, depth_select_high} = sel;
      drive = dv;
      wdata = d;
      @(posedge core_clk);
      #1;
   endtask

   task automatic nop;
      step(1'b0, 1'b1, 17'h0, 4'hf, IDL, 1'b0, '0);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_write_read;
      for (int k = 0; k < 11; k++) begin
         if (k < 4) mem[4+k] = pat(17'(4 + k));
         step(1'b0, k > 3, 17'(4 + k % 4), (k > 3) ? 4'hf : 4'h0,
              (k < 8) ? SEL : IDL, k inside {[2:5]}, pat(17'(k + 2)));
         if (k > 5 && k < 10) `CHK({oe_w, rd_w}, {4'hf, pat(17'(k - 2))})
         if (k == 10) `CHK(oe_w, 4'h0)
      end
   endtask

   task automatic t_lanes;
      sps_pkg::sps_word_t nd;
      for (int i = 0; i < 4; i++) begin
         nd = {4{9'(9'h1f0 + i)}};
         mem[4][i] = nd[i];
         step(1'b0, 1'b0, 17'h4, ~(4'h1 << i), SEL, 1'b0, '0);
         nop();
         step(1'b0, 1'b1, 17'h4, 4'hf, SEL, 1'b1, nd);
         nop();
         nop();
         `CHK(rd_w, mem[4])
      end
   endtask

   task automatic t_burst(input logic ord, input logic [16:0] b);
      logic [1:0] n;
      burst_order_select = ord;
      step(1'b0, 1'b1, b, 4'hf, SEL, 1'b0, '0);
      for (int k = 0; k < 6; k++) begin
         // selects and direction are junk during advance on purpose
         if (k < 4) step(1'b1, 1'b0, 17'h0, 4'hf, IDL, 1'b0, '0);
         else nop();
         n = 2'(k - 1);
         if (k > 0) `CHK(rd_w, mem[{b[2], ord ? b[1:0] ^ n : b[1:0] + n}])
      end
      burst_order_select = 1'b0;
   endtask

   task automatic t_desel;
      for (int i = 0; i < 3; i++) begin
         step(1'b0, 1'b1, 17'h5, 4'hf, SEL ^ (3'h1 << i), 1'b0, '0);
         nop();
         nop();
         `CHK(oe_w, 4'h0)
      end
   endtask

   task automatic t_freeze_oe;
      step(1'b0, 1'b1, 17'h7, 4'hf, SEL, 1'b0, '0);
      clock_enable_n = 1'b1;
      nop();
      nop();
      clock_enable_n = 1'b0;
      nop();
      `CHK(oe_w, 4'h0)
      nop();
      `CHK({oe_w, rd_w}, {4'hf, mem[7]})
      clock_enable_n = 1'b1;
      nop();
      nop();
      `CHK({oe_w, rd_w}, {4'hf, mem[7]})
      output_enable_n = 1'b1;
      #1;
      `CHK(oe_w, 4'h0)
      output_enable_n = 1'b0;
      #1;
      `CHK(oe_w, 4'hf)
      clock_enable_n = 1'b0;
   endtask

   task automatic t_sleep;
      sleep_request = 1'b1;
      repeat (5) nop();
      step(1'b0, 1'b0, 17'h7, 4'h0, SEL, 1'b0, '0);
      step(1'b0, 1'b1, 17'h7, 4'hf, SEL, 1'b0, '0);
      step(1'b0, 1'b1, 17'h7, 4'hf, SEL, 1'b1, '0);
      nop();
      `CHK(oe_w, 4'h0)
      sleep_request = 1'b0;
      repeat (6) nop();
      step(1'b0, 1'b1, 17'h7, 4'hf, SEL, 1'b0, '0);
      nop();
      nop();
      `CHK(rd_w, mem[7])
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // run is about 90 cycles; the limit leaves ample slack
   initial begin
      #20000;
      err_total++;
      end_sim();
   end

   initial begin
      rst_b = 1'b0;
      clock_enable_n = 1'b0;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
      burst_order_select = 1'b0;
      load_advance = 1'b0;
      read_write_n = 1'b1;
      word_address_in = '0;
      {burst_lsb_1, burst_lsb_0} = 2'h0;
      {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n} = 4'hf;
      {chip_select_n, depth_select_low_n, depth_select_high} = IDL;
      drive = 1'b0;
      wdata = '0;
      repeat (8) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      `CHK(oe_w, 4'h0)
      t_write_read();
      t_lanes();
      t_burst(1'b0, 17'h5);
      t_burst(1'b1, 17'h6);
      t_desel();
      t_freeze_oe();
      t_sleep();
      end_sim();
   end
endmodule
